// ---- rtl/vrc_top.sv ----
/*
 Voltage reference control register: one 8-bit control and status
 register with reference enable, ready flag, temperature indicator
 controls and ADC reference gain selector.
 Assumes a single 10 MHz clock, a plain register port whose master
 never issues read and write together, and an analog ready level
 that may change at any time.
*/
`timescale 1ns/1ns
`include "vrc_consts.svh"

module vrc_top #(
  parameter int ADDR_W      = 8,
  parameter bit STD_VARIANT = 1'b0
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [7:0]        WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  input  wire logic              REF_READY_IN,
  output logic      [7:0]        RDATA_OUT,
  output logic                   REF_ENABLE_OUT,
  output logic                   REF_READY_OUT,
  output logic                   TEMP_ENABLE_OUT,
  output logic                   TEMP_RANGE_OUT,
  output logic      [1:0]        ADC_GAIN_OUT,
  output logic                   ADC_REF_ON_OUT,
  output logic      [2:0]        ADC_GAIN_MULT_OUT
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************

  // Offset must fit in the address port
  generate
    if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr_w
      $error("vrc_top: ADDR_W must lie between 1 and 8");
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************

  vrc_pkg::vrc_state_t state;
  vrc_pkg::vrc_state_t next_state;

  localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(`VRC_CTRL_OFFSET);

  // Reset image, every field a constant
  localparam vrc_pkg::vrc_state_t RST_STATE = '{
    ctrl       : '{enable   : `VRC_RST_ENABLE,
                   temp_en  : `VRC_RST_TEMP_EN,
                   temp_rng : `VRC_RST_TEMP_RNG,
                   gain     : vrc_pkg::VRC_GAIN_OFF},
    sync_a     : 1'h0,
    sync_b     : 1'h0,
    ready      : STD_VARIANT,
    adc_ref_on : 1'h0,
    mult       : `VRC_MULT_OFF,
    rdata      : `VRC_RST_RDATA
  };

  // ****************************************************************
  // Decode
  // ****************************************************************

  logic ctrl_hit;
  logic ctrl_wr;
  logic ctrl_rd;

  // Address compare and qualified strobes
  always_comb begin
    ctrl_hit = (ADDR_IN == CTRL_ADDR);
    ctrl_wr  = WR_IN && ctrl_hit;
    ctrl_rd  = RD_IN && ctrl_hit;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Gain code to one-hot multiplier
  function automatic logic [2:0] gain_to_mult(input vrc_pkg::vrc_gain_t g);
    logic [2:0] m;
    m = `VRC_MULT_OFF;
    case (g)
      vrc_pkg::VRC_GAIN_X1: m = `VRC_MULT_X1;
      vrc_pkg::VRC_GAIN_X2: m = `VRC_MULT_X2;
      vrc_pkg::VRC_GAIN_X4: m = `VRC_MULT_X4;
      default:              m = `VRC_MULT_OFF;
    endcase
    return m;
  endfunction

  // Register write, ready tracking and read data
  always_comb begin
    next_state = state;

    // Writable fields take the write data
    if (ctrl_wr) begin
      next_state.ctrl.enable   = WDATA_IN[`VRC_BIT_ENABLE];
      next_state.ctrl.temp_en  = WDATA_IN[`VRC_BIT_TEMP_EN];
      next_state.ctrl.temp_rng = WDATA_IN[`VRC_BIT_TEMP_RNG];
      next_state.ctrl.gain     = vrc_pkg::vrc_gain_t'(
        WDATA_IN[`VRC_BIT_GAIN_HI:`VRC_BIT_GAIN_LO]);
      // Bits 3:2 and the ready bit are dropped
    end

    // Two-stage synchroniser on the analog ready level
    next_state.sync_a = REF_READY_IN;
    next_state.sync_b = state.sync_a;

    // Ready flag: forced on variant, else gated by enable
    if (STD_VARIANT) begin
      next_state.ready = 1'h1;
    end else begin
      next_state.ready = next_state.ctrl.enable && state.sync_b;
    end

    // ADC reference path follows gain code
    next_state.adc_ref_on = (next_state.ctrl.gain != vrc_pkg::VRC_GAIN_OFF);
    next_state.mult       = gain_to_mult(next_state.ctrl.gain);

    // Read data stand one cycle after the read strobe
    next_state.rdata = 8'h00;
    if (ctrl_rd) begin
      next_state.rdata[`VRC_BIT_ENABLE]   = state.ctrl.enable;
      next_state.rdata[`VRC_BIT_READY]    = state.ready;
      next_state.rdata[`VRC_BIT_TEMP_EN]  = state.ctrl.temp_en;
      next_state.rdata[`VRC_BIT_TEMP_RNG] = state.ctrl.temp_rng;
      next_state.rdata[`VRC_BIT_UNUSED_HI:`VRC_BIT_UNUSED_LO] = `VRC_UNUSED_READ;
      next_state.rdata[`VRC_BIT_GAIN_HI:`VRC_BIT_GAIN_LO]     = state.ctrl.gain;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Whole state in one flop bank
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= RST_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output straight from a flop
  always_comb begin
    RDATA_OUT         = state.rdata;
    REF_ENABLE_OUT    = state.ctrl.enable;
    REF_READY_OUT     = state.ready;
    TEMP_ENABLE_OUT   = state.ctrl.temp_en;
    TEMP_RANGE_OUT    = state.ctrl.temp_rng;
    ADC_GAIN_OUT      = state.ctrl.gain;
    ADC_REF_ON_OUT    = state.adc_ref_on;
    ADC_GAIN_MULT_OUT = state.mult;
  end

  // ****************************************************************
  // Assertion helpers
  // ****************************************************************

  logic seen_write;

  // Marks the first control write since reset
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      seen_write <= 1'h0;
    end else if (ctrl_wr) begin
      seen_write <= 1'h1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // Control write sequence
  sequence s_ctrl_write;
    WR_IN && (ADDR_IN == CTRL_ADDR);
  endsequence

  // Control read sequence
  sequence s_ctrl_read;
    RD_IN && (ADDR_IN == CTRL_ADDR);
  endsequence

  // Enabled with analog ready held four cycles
  sequence s_ready_held;
    (REF_ENABLE_OUT && REF_READY_IN)[*4];
  endsequence

  // Analog ready low for four cycles on the gated variant
  sequence s_ready_gone;
    (!STD_VARIANT && !REF_READY_IN)[*4];
  endsequence

  chk_enable_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_write |=> REF_ENABLE_OUT == $past(WDATA_IN[7]))
    else $error("reference enable did not take written bit 7");

  chk_ready_disabled: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!STD_VARIANT && !REF_ENABLE_OUT) |-> !REF_READY_OUT)
    else $error("ready flag high while reference disabled");

  chk_ready_cause: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!STD_VARIANT && $rose(REF_READY_OUT)) |-> $past(REF_READY_IN, 3))
    else $error("ready flag rose without analog ready three cycles before");

  chk_ready_nowrite: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_ctrl_write ##1 s_ctrl_read) |=>
      RDATA_OUT[6] == $past(REF_READY_OUT))
    else $error("ready bit read back differs from ready flag");

  chk_std_ready: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    STD_VARIANT |-> REF_READY_OUT)
    else $error("standard variant ready flag not one");

  chk_temp_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_write |=> TEMP_ENABLE_OUT == $past(WDATA_IN[5]))
    else $error("temperature enable did not take written bit 5");

  chk_range_write: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_write |=> TEMP_RANGE_OUT == $past(WDATA_IN[4]))
    else $error("range select did not take written bit 4");

  chk_unused_zero: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_read |=> RDATA_OUT[3:2] == 2'h0)
    else $error("unimplemented bits read nonzero");

  chk_gain_off: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_ctrl_write and WDATA_IN[1:0] == 2'h0) |=>
      !ADC_REF_ON_OUT && ADC_GAIN_MULT_OUT == 3'h0)
    else $error("gain code zero did not switch reference off");

  chk_gain_high: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_ctrl_write and WDATA_IN[1] == 1'h1) |=>
      ADC_GAIN_MULT_OUT == ($past(WDATA_IN[0]) ? 3'h4 : 3'h2))
    else $error("gain code 10 or 11 gave wrong multiplier");

  chk_gain_unity: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_ctrl_write and WDATA_IN[1:0] == 2'h1) |=>
      ADC_REF_ON_OUT && ADC_GAIN_MULT_OUT == 3'h1)
    else $error("gain code 01 did not give unity gain");

  chk_reset_fields: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !seen_write |-> !REF_ENABLE_OUT && !TEMP_ENABLE_OUT &&
      !TEMP_RANGE_OUT && ADC_GAIN_OUT == 2'h0)
    else $error("writable field not zero before first write");

  chk_ready_sync: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ready_held |-> REF_READY_OUT)
    else $error("ready flag not set after four cycles of ready input");

  chk_read_enable: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_read |=> RDATA_OUT[7] == $past(REF_ENABLE_OUT) &&
      RDATA_OUT[1:0] == $past(ADC_GAIN_OUT))
    else $error("read data do not show control fields");

  chk_read_ready: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_read |=> RDATA_OUT[6] == $past(REF_READY_OUT))
    else $error("ready bit in read data differs from ready flag");

  chk_read_temp: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ctrl_read |=> RDATA_OUT[5] == $past(TEMP_ENABLE_OUT) &&
      RDATA_OUT[4] == $past(TEMP_RANGE_OUT))
    else $error("read data do not show temperature fields");

  chk_read_idle: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !(RD_IN && ADDR_IN == CTRL_ADDR) |=> RDATA_OUT == 8'h00)
    else $error("read data not zero outside the read cycle");

  chk_fields_hold: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !(WR_IN && ADDR_IN == CTRL_ADDR) |=> $stable(REF_ENABLE_OUT) &&
      $stable(TEMP_ENABLE_OUT) && $stable(TEMP_RANGE_OUT) && $stable(ADC_GAIN_OUT))
    else $error("control field changed without a control write");

  chk_ready_gone: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_ready_gone |-> !REF_READY_OUT)
    else $error("ready flag high four cycles after analog ready fell");

  chk_ready_en_drop: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_ctrl_write and (!STD_VARIANT && !WDATA_IN[7])) |=> !REF_READY_OUT)
    else $error("ready flag stayed high after enable cleared");

  chk_ref_on_code: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_REF_ON_OUT == (ADC_GAIN_OUT != 2'h0))
    else $error("reference on flag disagrees with gain code");

  chk_mult_off: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_GAIN_OUT == 2'h0 |-> ADC_GAIN_MULT_OUT == 3'h0)
    else $error("gain code 00 gave a multiplier");

  chk_mult_x1: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_GAIN_OUT == 2'h1 |-> ADC_GAIN_MULT_OUT == 3'h1)
    else $error("gain code 01 multiplier not unity");

  chk_mult_x2: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_GAIN_OUT == 2'h2 |-> ADC_GAIN_MULT_OUT == 3'h2)
    else $error("gain code 10 multiplier not double");

  chk_mult_x4: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_GAIN_OUT == 2'h3 |-> ADC_GAIN_MULT_OUT == 3'h4)
    else $error("gain code 11 multiplier not quadruple");

endmodule // vrc_top

// ---- shared/vrc_consts.svh ----
/*
 Constants for the voltage reference control register block: register
 offset, field positions, reset values and gain multiplier codes.
 Assumes it is included by bare name wherever these values are needed.
*/
`ifndef VRC_CONSTS_SVH
`define VRC_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define VRC_CTRL_OFFSET 8'h00

// ****************************************************************
// Field positions in the control register
// ****************************************************************
`define VRC_BIT_ENABLE    7
`define VRC_BIT_READY     6
`define VRC_BIT_TEMP_EN   5
`define VRC_BIT_TEMP_RNG  4
`define VRC_BIT_UNUSED_HI 3
`define VRC_BIT_UNUSED_LO 2
`define VRC_BIT_GAIN_HI   1
`define VRC_BIT_GAIN_LO   0

// ****************************************************************
// Reset values
// ****************************************************************
`define VRC_RST_ENABLE   1'h0
`define VRC_RST_TEMP_EN  1'h0
`define VRC_RST_TEMP_RNG 1'h0
`define VRC_RST_GAIN     2'h0
`define VRC_RST_RDATA    8'h00
`define VRC_UNUSED_READ  2'h0

// ****************************************************************
// Gain multiplier one-hot codes
// ****************************************************************
`define VRC_MULT_OFF 3'h0
`define VRC_MULT_X1  3'h1
`define VRC_MULT_X2  3'h2
`define VRC_MULT_X4  3'h4

`endif

// ---- shared/vrc_pkg.sv ----
/*
 Types for the voltage reference control register block.
 Assumes the constants header is compiled alongside it.
*/
package vrc_pkg;

  // ****************************************************************
  // Gain selector codes
  // ****************************************************************
  typedef enum logic [1:0] {
    VRC_GAIN_OFF = 2'h0,
    VRC_GAIN_X1  = 2'h1,
    VRC_GAIN_X2  = 2'h2,
    VRC_GAIN_X4  = 2'h3
  } vrc_gain_t;

  // ****************************************************************
  // Software visible control fields
  // ****************************************************************
  typedef struct packed {
    logic      enable;
    logic      temp_en;
    logic      temp_rng;
    vrc_gain_t gain;
  } vrc_ctrl_t;

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    vrc_ctrl_t  ctrl;
    logic       sync_a;
    logic       sync_b;
    logic       ready;
    logic       adc_ref_on;
    logic [2:0] mult;
    logic [7:0] rdata;
  } vrc_state_t;

endpackage

// ---- testbench/vrc_testbench.sv ----
/*
 Self-checking bench for the voltage reference control register block.
 Assumes the constants header and package are compiled first. A second
 instance built as the standard variant shares all inputs.
*/
`timescale 1ns/1ns
`include "vrc_consts.svh"

module testbench;
  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       ready_in;
  logic [7:0] rdata;
  logic [7:0] std_rdata;
  logic       ref_en;
  logic       ref_rdy;
  logic       std_rdy;
  logic       temp_en;
  logic       temp_rng;
  logic [1:0] gain;
  logic       ref_on;
  logic [2:0] mult;
  int         error_cnt;
  int         n_checks;
  logic [7:0] rv;
  logic [7:0] sv;

  // ****************************************************************
  // Clock, initial values and the two instances
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0; ready_in = 1'b0;
  end

  vrc_top #(.ADDR_W(8), .STD_VARIANT(1'b0)) dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .REF_READY_IN(ready_in), .RDATA_OUT(rdata), .REF_ENABLE_OUT(ref_en),
    .REF_READY_OUT(ref_rdy), .TEMP_ENABLE_OUT(temp_en), .TEMP_RANGE_OUT(temp_rng),
    .ADC_GAIN_OUT(gain), .ADC_REF_ON_OUT(ref_on), .ADC_GAIN_MULT_OUT(mult));

  vrc_top #(.ADDR_W(8), .STD_VARIANT(1'b1)) dut_std (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .REF_READY_IN(ready_in), .RDATA_OUT(std_rdata), .REF_ENABLE_OUT(),
    .REF_READY_OUT(std_rdy), .TEMP_ENABLE_OUT(), .TEMP_RANGE_OUT(),
    .ADC_GAIN_OUT(), .ADC_REF_ON_OUT(), .ADC_GAIN_MULT_OUT());

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    sv = std_rdata;
  endtask

  // Control outputs against the expected field values
  task automatic check_outs(input logic [7:0] v);
    logic [2:0] m;
    m = (v[1:0] == 2'h0) ? 3'h0 : (v[1:0] == 2'h1) ? 3'h1 : (v[1:0] == 2'h2) ? 3'h2 : 3'h4;
    check({7'h00, ref_en}, {7'h00, v[7]}, "enable out");
    check({7'h00, temp_en}, {7'h00, v[5]}, "temp enable out");
    check({7'h00, temp_rng}, {7'h00, v[4]}, "temp range out");
    check({6'h00, gain}, {6'h00, v[1:0]}, "gain out");
    check({7'h00, ref_on}, {7'h00, v[1:0] != 2'h0}, "adc ref on");
    check({5'h00, mult}, {5'h00, m}, "gain multiplier");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values of both variants
  task automatic sc_reset_values();
    #1;
    check_outs(8'h00);
    reg_rd(`VRC_CTRL_OFFSET);
    check(rv, `VRC_RST_RDATA, "reset read");
    check(sv, 8'h40, "std variant reset read");
    @(posedge clk);
    #1;
    check(rdata, 8'h00, "read data after valid cycle");
  endtask

  // Every gain code with varied flag fields, each written and read back
  task automatic sc_fields();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[0], 1'b0, i[1], ~i[0], 2'h0, i[1:0]};
      reg_wr(`VRC_CTRL_OFFSET, v);
      check_outs(v);
      reg_rd(`VRC_CTRL_OFFSET);
      check(rv, v, "field read back");
      check(sv, v | 8'h40, "std variant read");
    end
  endtask

  // Ready bit and unused bits ignore writes; unmapped address
  task automatic sc_ignored();
    reg_wr(`VRC_CTRL_OFFSET, 8'h4C);
    check_outs(8'h00);
    reg_rd(`VRC_CTRL_OFFSET);
    check(rv, 8'h00, "ready and unused bits written");
    reg_wr(8'h01, 8'hBF);
    check_outs(8'h00);
    reg_rd(8'h01);
    check(rv, 8'h00, "unmapped address read");
  endtask

  // Ready through the synchroniser, gated by enable
  task automatic sc_ready();
    int n;
    ready_in <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check({7'h00, ref_rdy}, 8'h00, "ready while disabled");
    check({7'h00, std_rdy}, 8'h01, "std ready disabled");
    ready_in <= 1'b0;
    reg_wr(`VRC_CTRL_OFFSET, 8'h80);
    repeat (4) @(posedge clk);
    ready_in <= 1'b1;
    n = 0;
    while (ref_rdy !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8) begin
        error_cnt++;
        $display("[ERR] %0t ready never rose", $time);
        complete_run();
      end
    end
    check(n[7:0], 8'h03, "ready synchroniser delay");
    reg_rd(`VRC_CTRL_OFFSET);
    check(rv, 8'hC0, "ready read when stable");
    reg_wr(`VRC_CTRL_OFFSET, 8'h00);
    check({6'h00, ref_en, ref_rdy}, 8'h00, "ready drops with enable");
    check({7'h00, std_rdy}, 8'h01, "std ready after disable");
    ready_in <= 1'b0;
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic sc_back_to_back();
    @(posedge clk);
    wr <= 1'b1;
    addr <= `VRC_CTRL_OFFSET;
    wdata <= 8'h7D;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, 8'h31, "read right after write");
    check(std_rdata, 8'h71, "std read right after write");
  endtask

  // Reset in mid-run clears every writable field
  task automatic sc_mid_reset();
    reg_wr(`VRC_CTRL_OFFSET, 8'hB3);
    check_outs(8'hB3);
    do_reset();
    #1;
    check_outs(8'h00);
    reg_rd(`VRC_CTRL_OFFSET);
    check(rv, 8'h00, "read after mid-run reset");
    check(sv, 8'h40, "std read after mid-run reset");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    error_cnt = 0;
    n_checks = 0;
    do_reset();
    sc_reset_values();
    sc_fields();
    sc_ignored();
    sc_ready();
    sc_back_to_back();
    sc_mid_reset();
    complete_run();
  end
endmodule // testbench
